//--- verilog/osc_switch_defines.svh
`ifndef OSC_SWITCH_DEFINES_SVH
`define OSC_SWITCH_DEFINES_SVH

// Register map: word index is address bits 3:2.
`define WORD_SEL 3:2
`define OSC_CTRL_WORD 2'h0
`define UNLOCK_WORD 2'h1

// Unlock keys, written in this order to the unlock word. Values are arbitrary.
`define UNLOCK_KEY1 16'h5a5a
`define UNLOCK_KEY2 16'ha5a5

// Oscillator control field layout.
`define CUR_SRC_FIELD 14:12
`define NEXT_SRC_FIELD 10:8
`define FREEZE_BIT 7
`define PINMAP_BIT 6
`define LOCK_BIT 5
`define FAIL_FLAG_BIT 3
`define SWITCH_REQ_BIT 0
`define OSC_UNUSED_MASK 16'h8816
`define OSC_RESET_WORD 16'h0000
`define SRC_RESERVED 3'h4

// Byte lanes of the 16-bit register.
`define LANE_HI 1
`define LANE_LO 0
`define LANES_BOTH 2'h3

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Synchroniser lanes.
`define SY_PLL_LOCK 0
`define SY_PLL_TIMER 1
`define SY_CLK_FAIL 2
`define SY_SRC_READY 3

// Cycles the new source runs before it is committed, minus one.
`define SETTLE_LAST 4'hf
`define SETTLE_ZERO 4'h0
`define SETTLE_ONE 4'h1

`endif

//--- verilog/osc_switch_pkg.sv
package osc_switch_pkg;
    typedef logic [2:0] source_type;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_WAIT = 2'b01,
        SEQ_SETTLE = 2'b10,
        SEQ_FINISH = 2'b11
    } seq_state_type;
    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_KEY1 = 2'b01,
        UL_OPEN = 2'b10
    } unlock_state_type;
endpackage : osc_switch_pkg

//--- verilog/switch_if.sv
`timescale 1ns/1ns
interface switch_if;
    import osc_switch_pkg::*;
    logic req;
    source_type target;
    logic ready;
    source_type por;
    logic busy;
    logic done;
    logic start;
    source_type current;
    modport ctrl (output req, output target, output ready, output por,
                  input busy, input done, input start, input current);
    modport seq (input req, input target, input ready, input por,
                 output busy, output done, output start, output current);
endinterface : switch_if

//--- verilog/unlock_guard.sv
`timescale 1ns/1ns
`include "osc_switch_defines.svh"
module unlock_guard
    import osc_switch_pkg::*;
(
    input logic clk,
    input logic reset,
    input logic ce,
    input logic wr_fire,
    input logic wr_unlock,
    input logic [15:0] key,
    output logic write_ok
);
    unlock_state_type state_q;

    assign write_ok = state_q == UL_OPEN;

    // Any write that does not continue the key sequence drops it, and the
    // write following a completed sequence consumes it.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= UL_IDLE;
        end else if (ce && wr_fire) begin
            unique case (state_q)
                UL_IDLE: state_q <= (wr_unlock && key == `UNLOCK_KEY1) ? UL_KEY1 : UL_IDLE;
                UL_KEY1: state_q <= (wr_unlock && key == `UNLOCK_KEY2) ? UL_OPEN : UL_IDLE;
                UL_OPEN: state_q <= (wr_unlock && key == `UNLOCK_KEY1) ? UL_KEY1 : UL_IDLE;
                default: state_q <= UL_IDLE;
            endcase
        end
    end
endmodule : unlock_guard

//--- verilog/switch_sequencer.sv
`timescale 1ns/1ns
`include "osc_switch_defines.svh"
module switch_sequencer
    import osc_switch_pkg::*;
(
    input logic clk,
    input logic reset,
    input logic ce,
    switch_if.seq sw
);
    seq_state_type state_q;
    source_type current_q;
    logic [3:0] settle_q;

    assign sw.busy = state_q != SEQ_IDLE;
    assign sw.done = state_q == SEQ_FINISH;
    assign sw.start = state_q == SEQ_WAIT;
    assign sw.current = current_q;

    // A switch to the source already in use finishes at once.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= SEQ_IDLE;
        end else if (ce) begin
            unique case (state_q)
                SEQ_IDLE: if (sw.req) state_q <= (sw.target == current_q) ? SEQ_FINISH : SEQ_WAIT;
                SEQ_WAIT: if (sw.ready) state_q <= SEQ_SETTLE;
                SEQ_SETTLE: if (settle_q == `SETTLE_LAST) state_q <= SEQ_FINISH;
                SEQ_FINISH: state_q <= SEQ_IDLE;
            endcase
        end
    end

    // The settle wait lets the new source run a while before the mux moves,
    // trading switch latency for a glitch-free handover.
    always_ff @(posedge clk) begin
        if (reset) begin
            settle_q <= `SETTLE_ZERO;
        end else if (ce) begin
            settle_q <= (state_q == SEQ_SETTLE) ? settle_q + `SETTLE_ONE : `SETTLE_ZERO;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            current_q <= sw.por;
        end else if (ce && state_q == SEQ_FINISH) begin
            current_q <= sw.target;
        end
    end
endmodule : switch_sequencer

//--- verilog/oscillator_switch_control.sv
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "osc_switch_defines.svh"
// Function
// - Read-only current source field shows the source really in use.
// - Writable next source field uses the same codes; code 100 is reserved.
// - Writing one to switch_request starts a switch to next_source_sel.
// - switch_request returns to zero when the switch has finished.
// - Freeze bit plus failsafe_cfg_bit0 both set block clock and PLL changes.
// - pin_map_freeze is a writable bit; one means the I/O lock is active.
// - Lock status is one when the PLL is enabled and locked or its timer expired, else zero.
// - clock_fail_flag sets when the fail-safe monitor sees a clock failure.
// - Software writing the flag to one acts as a failure and raises the trap.
// - Bits 15, 11, 4 and 2 to 1 always read as zero.
// - Power-on reset loads next_source_sel from the configuration bits.
module oscillator_switch_control
    import osc_switch_pkg::*;
(
    input logic clk,
    input logic reset,
    input logic ce,
    input logic [3:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [3:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [2:0] por_source_sel,
    input logic failsafe_cfg_bit0,
    input logic pll_enabled,
    input logic pll_locked_async,
    input logic pll_timer_done_async,
    input logic clock_fail_async,
    input logic source_ready_async,
    output logic source_start,
    output logic [2:0] source_target,
    output logic [2:0] sys_clock_sel,
    output logic clock_fail_trap,
    output logic pin_map_freeze,
    output logic clock_cfg_locked
);
    function automatic logic is_osc(input logic [3:0] a);
        return a[`WORD_SEL] == `OSC_CTRL_WORD;
    endfunction : is_osc

    function automatic logic is_mapped(input logic [3:0] a);
        return is_osc(a) || a[`WORD_SEL] == `UNLOCK_WORD;
    endfunction : is_mapped

    switch_if sw ();

    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic fail_prev_q;
    logic aw_held_q;
    logic w_held_q;
    logic [3:0] awaddr_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    source_type next_q;
    logic freeze_q;
    logic pinmap_q;
    logic swreq_q;
    logic cf_q;
    logic trap_q;
    logic [15:0] osc_rd;
    logic unlock_ok;
    logic wr_fire;
    logic osc_wr;
    logic lo_wr;
    logic hi_wr;
    logic fail_evt;
    logic sw_set;
    logic sw_clr;
    logic lock_stat;

    // Pins from other clock domains pass two flip-flops before use.
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else if (ce) begin
            sync1_q <= {source_ready_async, clock_fail_async, pll_timer_done_async,
                        pll_locked_async};
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fail_prev_q <= 1'b0;
        end else if (ce) begin
            fail_prev_q <= sync2_q[`SY_CLK_FAIL];
        end
    end

    // Write channel: address and data are taken in either order and held.
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            w_held_q <= 1'b0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata[15:0];
                wstrb_q <= s_axi_wstrb[1:0];
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= is_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    unlock_guard u_unlock (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .wr_fire(wr_fire),
        .wr_unlock(awaddr_q[`WORD_SEL] == `UNLOCK_WORD && wstrb_q == `LANES_BOTH),
        .key(wdata_q),
        .write_ok(unlock_ok)
    );

    // A control write that is not unlocked is answered OKAY but dropped.
    assign osc_wr = wr_fire && is_osc(awaddr_q) && unlock_ok;
    assign hi_wr = osc_wr && wstrb_q[`LANE_HI];
    assign lo_wr = osc_wr && wstrb_q[`LANE_LO];
    assign clock_cfg_locked = freeze_q && failsafe_cfg_bit0;

    // Reserved codes and writes during a pending switch are dropped so that
    // the sequencer target stays steady.
    always_ff @(posedge clk) begin
        if (reset) begin
            next_q <= por_source_sel;
        end else if (ce && hi_wr && !clock_cfg_locked && !swreq_q &&
                     wdata_q[`NEXT_SRC_FIELD] != `SRC_RESERVED) begin
            next_q <= wdata_q[`NEXT_SRC_FIELD];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            freeze_q <= 1'b0;
        end else if (ce && lo_wr && !clock_cfg_locked) begin
            freeze_q <= wdata_q[`FREEZE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pinmap_q <= 1'b0;
        end else if (ce && lo_wr) begin
            pinmap_q <= wdata_q[`PINMAP_BIT];
        end
    end

    // Writing zero cannot abort a switch in progress.
    always_ff @(posedge clk) begin
        if (reset) begin
            swreq_q <= 1'b0;
        end else if (ce) begin
            if (sw.done) begin
                swreq_q <= 1'b0;
            end else if (lo_wr && wdata_q[`SWITCH_REQ_BIT] && !clock_cfg_locked) begin
                swreq_q <= 1'b1;
            end
        end
    end

    assign sw.req = swreq_q && !sw.busy;
    assign sw.target = next_q;
    assign sw.ready = sync2_q[`SY_SRC_READY];
    assign sw.por = por_source_sel;

    switch_sequencer u_seq (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .sw(sw)
    );

    // The set wins over a clear written in the same cycle.
    assign fail_evt = sync2_q[`SY_CLK_FAIL] && !fail_prev_q;
    assign sw_set = lo_wr && wdata_q[`FAIL_FLAG_BIT];
    assign sw_clr = lo_wr && !wdata_q[`FAIL_FLAG_BIT];

    always_ff @(posedge clk) begin
        if (reset) begin
            cf_q <= 1'b0;
        end else if (ce) begin
            if (fail_evt || sw_set) begin
                cf_q <= 1'b1;
            end else if (sw_clr) begin
                cf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trap_q <= 1'b0;
        end else if (ce) begin
            trap_q <= fail_evt || sw_set;
        end
    end

    assign lock_stat = pll_enabled &&
                       (sync2_q[`SY_PLL_LOCK] || sync2_q[`SY_PLL_TIMER]);

    always_comb begin
        osc_rd = `OSC_RESET_WORD;
        osc_rd[`CUR_SRC_FIELD] = sw.current;
        osc_rd[`NEXT_SRC_FIELD] = next_q;
        osc_rd[`FREEZE_BIT] = freeze_q;
        osc_rd[`PINMAP_BIT] = pinmap_q;
        osc_rd[`LOCK_BIT] = lock_stat;
        osc_rd[`FAIL_FLAG_BIT] = cf_q;
        osc_rd[`SWITCH_REQ_BIT] = swreq_q;
    end

    // Read channel: one outstanding read, data one cycle after the address.
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rdata_q <= {16'h0000, is_osc(s_axi_araddr) ? osc_rd : 16'h0000};
                rresp_q <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign source_start = sw.start;
    assign source_target = next_q;
    assign sys_clock_sel = sw.current;
    assign clock_fail_trap = trap_q;
    assign pin_map_freeze = pinmap_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !ce);

    property p_current_shown;
        rvalid_q && $past(is_osc(s_axi_araddr) && s_axi_arready && s_axi_arvalid) |->
            rdata_q[`CUR_SRC_FIELD] == $past(sys_clock_sel);
    endproperty
    a_current_shown: assert property (p_current_shown) else $error("current source misreported");

    property p_next_legal;
        $changed(next_q) |-> next_q != `SRC_RESERVED;
    endproperty
    a_next_legal: assert property (p_next_legal) else $error("reserved source stored");

    property p_switch_starts;
        $rose(swreq_q) |-> ##1 sw.busy;
    endproperty
    a_switch_starts: assert property (p_switch_starts) else $error("switch not started");

    property p_switch_clears;
        sw.done |=> !swreq_q && sys_clock_sel == $past(next_q);
    endproperty
    a_switch_clears: assert property (p_switch_clears) else $error("request not cleared");

    property p_freeze_blocks;
        osc_wr && clock_cfg_locked |=> $stable(next_q) && !$rose(swreq_q) && freeze_q;
    endproperty
    a_freeze_blocks: assert property (p_freeze_blocks) else $error("locked setting changed");

    property p_pinmap_write;
        lo_wr |=> pin_map_freeze == $past(wdata_q[`PINMAP_BIT]);
    endproperty
    a_pinmap_write: assert property (p_pinmap_write) else $error("pin lock not written");

    property p_lock_off;
        s_axi_arvalid && s_axi_arready && is_osc(s_axi_araddr) && !pll_enabled |=>
            s_axi_rvalid && !s_axi_rdata[`LOCK_BIT];
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock shown with PLL off");

    property p_fail_sets;
        fail_evt |=> cf_q && clock_fail_trap;
    endproperty
    a_fail_sets: assert property (p_fail_sets) else $error("failure not flagged");

    property p_sw_trap;
        sw_set ##1 !fail_evt |-> clock_fail_trap && cf_q;
    endproperty
    a_sw_trap: assert property (p_sw_trap) else $error("software set gave no trap");

    property p_unused_zero;
        s_axi_rvalid |-> (s_axi_rdata[15:0] & `OSC_UNUSED_MASK) == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

    property p_por_load;
        $fell(reset) |-> next_q == $past(por_source_sel);
    endproperty
    a_por_load: assert property (p_por_load) else $error("reset source not loaded");

    property p_locked_ignored;
        wr_fire && is_osc(awaddr_q) && !unlock_ok |=> $stable(pin_map_freeze) && $stable(next_q);
    endproperty
    a_locked_ignored: assert property (p_locked_ignored) else $error("write without unlock");

    c_switch_done: cover property (sw.done && sw.current != next_q);
    c_fail_trap: cover property (fail_evt);
    c_sw_trap: cover property (sw_set);
    c_blocked: cover property (osc_wr && clock_cfg_locked);
endmodule : oscillator_switch_control

//--- test/test_oscillator_switch_control.sv
`timescale 1ns/1ns
`include "osc_switch_defines.svh"
module test_oscillator_switch_control;
    typedef struct packed {
        logic [15:0] wr;
        logic [15:0] rd;
        logic pmf;
        logic [2:0] tgt;
    } row_type;
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] por_sel = 3'h2;
    logic fs_bit0 = 1'b0, pll_en = 1'b0, pll_lk = 1'b0, pll_tm = 1'b0;
    logic fail_in = 1'b0, src_rdy = 1'b0;
    logic source_start, trap, pmf, cfg_locked;
    logic [2:0] target, sys_sel;
    int n_errors = 0, checked = 0, cycles = 0, traps = 0;
    row_type rows[5] = '{
        '{16'h0240, 16'h2240, 1'b1, 3'h2},
        '{16'hfa16, 16'h2200, 1'b0, 3'h2},
        '{16'h0400, 16'h2200, 1'b0, 3'h2},
        '{16'h0740, 16'h2740, 1'b1, 3'h7},
        '{16'h0000, 16'h2000, 1'b0, 3'h0}};

    oscillator_switch_control uut (.clk(clk), .reset(reset), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .por_source_sel(por_sel),
        .failsafe_cfg_bit0(fs_bit0), .pll_enabled(pll_en), .pll_locked_async(pll_lk),
        .pll_timer_done_async(pll_tm), .clock_fail_async(fail_in),
        .source_ready_async(src_rdy), .source_start(source_start),
        .source_target(target), .sys_clock_sel(sys_sel), .clock_fail_trap(trap),
        .pin_map_freeze(pmf), .clock_cfg_locked(cfg_locked));

    always #10 clk = ~clk;

    // Trap is a one-cycle pulse, so count it at every edge.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (trap === 1'b1) traps <= traps + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            end_of_test();
        end
    end

    task end_of_test();
        $display("errors %0d of %0d comparisons", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task check_val(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task check_resp(input logic [1:0] got, input logic [1:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch time=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask : check_resp

    // Address and data are offered together; each is dropped once taken.
    task axi_write(input logic [3:0] a, input logic [15:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {16'h0000, d};
        wstrb <= 4'h3;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task ctl_write(input logic [15:0] d);
        logic [1:0] r;
        axi_write(4'h4, `UNLOCK_KEY1, r);
        axi_write(4'h4, `UNLOCK_KEY2, r);
        axi_write(4'h0, d, r);
        check_resp(r, `RESP_OKAY);
    endtask : ctl_write

    task ctl_read(input logic [15:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(4'h0, d, r);
        check_val(d, {16'h0000, exp});
        check_resp(r, `RESP_OKAY);
    endtask : ctl_read

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int t0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check_val(32'(sys_sel), 32'h0000_0002);
        check_val(32'(target), 32'h0000_0002);
        ctl_read(16'h2200);
        foreach (rows[i]) begin
            ctl_write(rows[i].wr);
            ctl_read(rows[i].rd);
            check_val(32'(pmf), 32'(rows[i].pmf));
            check_val(32'(target), 32'(rows[i].tgt));
        end
        axi_write(4'h0, 16'h0740, r);
        ctl_read(16'h2000);
        axi_write(4'h8, 16'h0001, r);
        check_resp(r, `RESP_SLVERR);
        axi_read(4'hc, d, r);
        check_val(d, 32'h0000_0000);
        check_resp(r, `RESP_SLVERR);
        // Primary to plain FRC, never straight between the two PLL sources.
        ctl_write(16'h0001);
        repeat (4) @(posedge clk);
        check_val(32'(source_start), 32'h0000_0001);
        ctl_read(16'h2001);
        check_val(32'(sys_sel), 32'h0000_0002);
        src_rdy <= 1'b1;
        d = 32'h0000_0001;
        for (int i = 0; i < 40 && d[0] !== 1'b0; i++) axi_read(4'h0, d, r);
        check_val(d, 32'h0000_0000);
        check_val(32'(sys_sel), 32'h0000_0000);
        src_rdy <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            {pll_en, pll_lk, pll_tm} <= 3'(6 - i - (i == 0 ? 0 : 0));
            repeat (6) @(posedge clk);
            axi_read(4'h0, d, r);
            check_val(32'(d[5]), 32'(i < 2));
        end
        t0 = traps;
        fail_in <= 1'b1;
        repeat (8) @(posedge clk);
        fail_in <= 1'b0;
        ctl_read(16'h0008);
        check_val(32'(traps - t0), 32'h0000_0001);
        ctl_write(16'h0000);
        ctl_read(16'h0000);
        ctl_write(16'h0008);
        ctl_read(16'h0008);
        check_val(32'(traps - t0), 32'h0000_0002);
        fs_bit0 <= 1'b1;
        // This write also clears the fail flag, which stays writable.
        ctl_write(16'h0080);
        check_val(32'(cfg_locked), 32'h0000_0001);
        ctl_write(16'h0381);
        ctl_read(16'h0080);
        fs_bit0 <= 1'b0;
        @(posedge clk);
        check_val(32'(cfg_locked), 32'h0000_0000);
        ctl_write(16'h0280);
        ctl_read(16'h0280);
        por_sel <= 3'h5;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check_val(32'(sys_sel), 32'h0000_0005);
        ctl_read(16'h5500);
        check_val(32'(pmf), 32'h0000_0000);
        end_of_test();
    end
endmodule : test_oscillator_switch_control
